// ---- logic/tio_port.v ----
// Timed I/O port: FIFO, serializer, port counter, clock blocks, pins
//
// Notes on behaviour
// - Port width is 1, 4, 8, 16 or 32 pins, all in one direction.
// - Direction belongs to the whole port, never per pin.
// - Open-collector ports drive low for a zero and float for a one.
// - The port drives its pins or samples them, sampling optionally on a condition.
// - Each core access waits on valid/ready; writes complete on an output port once the FIFO has room, reads on an input port once it has data.
// - Data passes through a serializer and a 16-word FIFO of transfer words.
// - A 16-bit port counter lets transfers wait for a chosen count.
// - The counter value is readable at any time without side effect.
// - Each transfer captures the counter as a timestamp.
// - An enabled link takes the pins away from the port.
// - A narrower enabled port wins the pins it shares with this one.
// - The port still transfers its full width when pins are taken.
// - Six clock blocks exist; block zero is the tile reference.
// - A clock block may take a 1-bit port pin as source and divide it.
// - The port honours a strobe input and drives a strobe output.
// - After reset the port runs from clock block zero.
`timescale 1ns/1ps
`include "tio_map.vh"
module tio_port #(
   parameter WIDTH = `TIO_WIDTH_DEF,
   parameter XFER_W = `TIO_XFER_W,
   parameter FIFO_DEPTH = `TIO_FIFO_DEPTH,
   parameter FIFO_AW = `TIO_FIFO_AW,
   parameter DIV_W = `TIO_CB_DIV_W
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Port configuration
   input wire cfg_port_en,
   input wire cfg_dir_out,
   input wire cfg_open_coll,
   input wire cfg_strobe_in_en,
   // Clock block configuration
   input wire clk_sel_set,
   input wire [`TIO_CB_SEL_W-1:0] clk_sel,
   input wire [`TIO_CB_NUM-2:0] cb_src_ext,
   input wire [(`TIO_CB_NUM-1)*DIV_W-1:0] cb_div,
   input wire cb_src_pin,
   // Pin sharing
   input wire link_en,
   input wire [WIDTH-1:0] narrow_taken,
   // Core write side
   input wire core_wr_valid,
   input wire [XFER_W-1:0] core_wr_data,
   output wire core_wr_ready,
   // Core read side
   output wire core_rd_valid,
   output wire [XFER_W-1:0] core_rd_data,
   input wire core_rd_ready,
   // Timed and conditional transfer
   input wire time_set,
   input wire [`TIO_CNT_W-1:0] time_value,
   input wire cond_set,
   input wire [1:0] cond_mode,
   input wire [WIDTH-1:0] cond_value,
   // Status
   output wire [`TIO_CNT_W-1:0] port_count,
   output wire [`TIO_CNT_W-1:0] port_stamp,
   output wire [`TIO_CB_SEL_W-1:0] clk_sel_now,
   output wire time_armed,
   output wire cond_armed,
   output wire overrun,
   input wire overrun_clr,
   // Pins
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] pin_out,
   output wire [WIDTH-1:0] pin_oe_n,
   input wire strobe_input,
   output wire strobe_output
);
   localparam integer SLICES = XFER_W / WIDTH;
   localparam integer SLC_LAST_I = SLICES - 1;
   localparam [`TIO_SLC_W-1:0] SLC_LAST = SLC_LAST_I[`TIO_SLC_W-1:0];
   localparam [`TIO_SLC_W-1:0] SLC_ZERO = {`TIO_SLC_W{1'b0}};

   // Clock block selection
   reg [`TIO_CB_SEL_W-1:0] clk_sel_reg;
   wire [`TIO_CB_NUM-1:0] cb_tick;
   wire [`TIO_CB_NUM-1:0] src_all;
   wire [`TIO_CB_NUM*DIV_W-1:0] div_all;
   wire port_tick;
   wire sel_ok;

   // Counter, schedule and condition
   reg [`TIO_CNT_W-1:0] count_reg;
   reg [`TIO_CNT_W-1:0] stamp_reg;
   reg [`TIO_CNT_W-1:0] time_reg;
   reg time_arm_reg;
   reg [1:0] cond_mode_reg;
   reg [WIDTH-1:0] cond_val_reg;
   wire time_ok;
   reg cond_ok;
   wire [`TIO_CNT_W-1:0] count_next;

   // Serializer and pins
   reg [XFER_W-1:0] sh_reg;
   reg [`TIO_SLC_W-1:0] slc_reg;
   reg [WIDTH-1:0] pin_reg;
   reg strobe_out_reg;
   reg word_pend_reg;
   reg overrun_reg;
   wire [WIDTH-1:0] avail;
   wire [WIDTH-1:0] samp;
   wire [XFER_W-1:0] shift_in;
   wire strobe_ok;
   wire out_step;
   wire in_step;
   wire load_out;
   wire first_in;
   wire last_in;
   wire out_shift;
   wire in_take;
   wire xfer_start;
   wire lost_tick;
   wire pend_done;

   // FIFO wiring
   wire fifo_in_valid;
   wire [XFER_W-1:0] fifo_in_data;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [XFER_W-1:0] fifo_out_data;
   wire fifo_out_ready;

   assign src_all = {cb_src_ext, 1'b0};
   assign div_all = {cb_div, {DIV_W{1'b0}}};

   // Block zero is the fixed reference; it ticks every sys_clk cycle
   genvar i;
   generate
      for (i = 0; i < `TIO_CB_NUM; i = i + 1) begin : g_cb
         tio_clkblk #(
            .DIV_W(DIV_W)
         ) u_cb (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .src_ext(src_all[i]),
            .div(div_all[i*DIV_W +: DIV_W]),
            .ext_pin(cb_src_pin),
            .tick(cb_tick[i])
         );
      end
   endgenerate

   assign port_tick = cb_tick[clk_sel_reg] & cfg_port_en;

   // An out-of-range block number is dropped rather than wrapped
   assign sel_ok = clk_sel_set & (clk_sel <= `TIO_CB_LAST);

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         clk_sel_reg <= `TIO_CB_REF;
      end else if (sel_ok) begin
         clk_sel_reg <= clk_sel;
      end
   end

   // Pins taken by a link or a narrower port read as zero
   assign avail = ~narrow_taken & ~{WIDTH{link_en}};
   assign samp = pin_in & avail;

   // Whole-port direction; open collector floats ones
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         assign pin_out[i] = ~cfg_open_coll & pin_reg[i];
         assign pin_oe_n[i] = ~(cfg_dir_out & cfg_port_en & avail[i]) |
            (cfg_open_coll & pin_reg[i]);
      end
   endgenerate
   assign strobe_output = strobe_out_reg;

   // Schedule against the counter and pin condition
   assign time_ok = ~time_arm_reg | (count_reg == time_reg);
   // An unknown mode never releases a waiting sample
   always @* begin
      case (cond_mode_reg)
         `TIO_COND_NONE: begin
            cond_ok = 1'b1;
         end
         `TIO_COND_EQ: begin
            cond_ok = (samp == cond_val_reg);
         end
         `TIO_COND_NE: begin
            cond_ok = (samp != cond_val_reg);
         end
         default: begin
            cond_ok = 1'b0;
         end
      endcase
   end
   assign strobe_ok = ~cfg_strobe_in_en | strobe_input;

   assign out_step = port_tick & cfg_dir_out & strobe_ok;
   assign load_out = out_step & (slc_reg == SLC_ZERO) & fifo_out_valid &
      time_ok;
   assign in_step = port_tick & ~cfg_dir_out & strobe_ok & ~word_pend_reg;
   assign first_in = in_step & (slc_reg == SLC_ZERO) & time_ok & cond_ok;
   assign last_in = (slc_reg == SLC_LAST);
   assign out_shift = out_step & (slc_reg != SLC_ZERO);
   assign in_take = in_step & ((slc_reg != SLC_ZERO) | first_in);
   assign xfer_start = load_out | first_in;
   // A tick that finds the last word not yet pushed into the FIFO is lost
   assign lost_tick = port_tick & ~cfg_dir_out & word_pend_reg;
   assign pend_done = word_pend_reg & fifo_in_ready;

   // Incoming slices enter at the top so the first lands in the low bits
   generate
      if (XFER_W == WIDTH) begin : g_one
         assign shift_in = samp;
      end else begin : g_many
         assign shift_in = {samp, sh_reg[XFER_W-1:WIDTH]};
      end
   endgenerate

   // Port counter advances on every port clock tick, strobe or not
   assign count_next = port_tick ? count_reg + `TIO_CNT_INC : count_reg;

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         count_reg <= `TIO_CNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   // Time arming; a new set wins over the disarm of the same cycle
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         time_reg <= `TIO_CNT_RST;
         time_arm_reg <= 1'b0;
      end else if (time_set) begin
         time_reg <= time_value;
         time_arm_reg <= 1'b1;
      end else if (xfer_start) begin
         time_arm_reg <= 1'b0;
      end
   end

   // The condition releases itself once the sample is taken
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         cond_mode_reg <= `TIO_COND_NONE;
         cond_val_reg <= {WIDTH{1'b0}};
      end else if (cond_set) begin
         cond_mode_reg <= cond_mode;
         cond_val_reg <= cond_value;
      end else if (first_in) begin
         cond_mode_reg <= `TIO_COND_NONE;
      end
   end

   // Serializer, transfer word and timestamp
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         sh_reg <= {XFER_W{1'b0}};
         slc_reg <= SLC_ZERO;
         pin_reg <= {WIDTH{1'b0}};
         strobe_out_reg <= 1'b0;
         stamp_reg <= `TIO_CNT_RST;
         word_pend_reg <= 1'b0;
      end else if (cfg_dir_out) begin
         word_pend_reg <= 1'b0;
         if (out_shift) begin
            pin_reg <= sh_reg[WIDTH-1:0];
            sh_reg <= sh_reg >> WIDTH;
            slc_reg <= slc_reg - 1'b1;
            strobe_out_reg <= 1'b1;
         end else if (load_out) begin
            pin_reg <= fifo_out_data[WIDTH-1:0];
            sh_reg <= fifo_out_data >> WIDTH;
            slc_reg <= SLC_LAST;
            stamp_reg <= count_reg;
            strobe_out_reg <= 1'b1;
         end else if (port_tick) begin
            strobe_out_reg <= 1'b0;
         end
      end else begin
         strobe_out_reg <= 1'b0;
         if (pend_done) begin
            word_pend_reg <= 1'b0;
         end
         if (in_take) begin
            sh_reg <= shift_in;
            if (slc_reg == SLC_ZERO) begin
               stamp_reg <= count_reg;
            end
            if (last_in) begin
               slc_reg <= SLC_ZERO;
               word_pend_reg <= 1'b1;
            end else begin
               slc_reg <= slc_reg + 1'b1;
            end
         end
      end
   end

   // A tick lost while the last word waits to enter the FIFO is flagged; the set wins over a clear
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         overrun_reg <= 1'b0;
      end else if (lost_tick) begin
         overrun_reg <= 1'b1;
      end else if (overrun_clr) begin
         overrun_reg <= 1'b0;
      end
   end

   // One FIFO serves whichever direction the port is set to
   assign fifo_in_valid = cfg_dir_out ? core_wr_valid : word_pend_reg;
   assign fifo_in_data = cfg_dir_out ? core_wr_data : sh_reg;
   assign fifo_out_ready = cfg_dir_out ? load_out : core_rd_ready;
   assign core_wr_ready = cfg_dir_out & fifo_in_ready;
   assign core_rd_valid = ~cfg_dir_out & fifo_out_valid;
   assign core_rd_data = fifo_out_data;

   tio_fifo #(
      .WIDTH(XFER_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready)
   );

   // Reading the counter has no side effect
   assign port_count = count_reg;
   assign port_stamp = stamp_reg;
   assign clk_sel_now = clk_sel_reg;
   assign time_armed = time_arm_reg;
   assign cond_armed = (cond_mode_reg != `TIO_COND_NONE);
   assign overrun = overrun_reg;
endmodule

// ---- logic/tio_map.vh ----
// Constants for the timed I/O port and its clock blocks
`ifndef TIO_MAP_VH
`define TIO_MAP_VH
`define TIO_WIDTH_DEF 4
`define TIO_XFER_W 32
`define TIO_CNT_W 16
`define TIO_FIFO_DEPTH 16
`define TIO_FIFO_AW 4
`define TIO_CB_NUM 6
`define TIO_CB_SEL_W 3
`define TIO_CB_REF 3'h0
`define TIO_CB_LAST 3'h5
`define TIO_CB_DIV_W 8
`define TIO_REF_CLK_MHZ 100
`define TIO_SLC_W 6
`define TIO_COND_NONE 2'h0
`define TIO_COND_EQ 2'h1
`define TIO_COND_NE 2'h2
`define TIO_CNT_RST 16'h0000
`define TIO_CNT_INC 16'h0001
`endif

// ---- logic/tio_fifo.v ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tio_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Fill side
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output wire in_ready,
   // Drain side
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] fill_reg;
   wire push;
   wire pop;
   localparam integer DEPTH_I = DEPTH;
   localparam integer LAST_I = DEPTH - 1;
   localparam [AW:0] DEPTH_C = DEPTH_I[AW:0];
   localparam [AW-1:0] LAST_C = LAST_I[AW-1:0];

   assign in_ready = (fill_reg != DEPTH_C);
   assign out_valid = (fill_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         fill_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? {AW{1'b0}} :
               wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? {AW{1'b0}} :
               rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            fill_reg <= fill_reg + 1'b1;
         end else if (pop && !push) begin
            fill_reg <= fill_reg - 1'b1;
         end
      end
   end
endmodule

// ---- logic/tio_clkblk.v ----
// One clock block: a tick source from the reference or a 1-bit port pin
`timescale 1ns/1ps
`include "tio_map.vh"
module tio_clkblk #(
   parameter DIV_W = `TIO_CB_DIV_W
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Configuration
   input wire src_ext,
   input wire [DIV_W-1:0] div,
   // Source pin
   input wire ext_pin,
   // Tick out
   output wire tick
);
   reg ext_prev_reg;
   reg [DIV_W-1:0] div_cnt_reg;
   wire src_event;

   // Pin is synchronous to sys_clk, so a plain edge detect is enough
   assign src_event = src_ext ? (ext_pin & ~ext_prev_reg) : 1'b1;
   assign tick = src_event & (div_cnt_reg == div);

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         ext_prev_reg <= 1'b0;
         div_cnt_reg <= {DIV_W{1'b0}};
      end else begin
         ext_prev_reg <= ext_pin;
         if (src_event) begin
            div_cnt_reg <= (div_cnt_reg == div) ? {DIV_W{1'b0}} :
               div_cnt_reg + 1'b1;
         end
      end
   end
endmodule

// ---- sim/tio_port_monitor.sv ----
// Concurrent checks on the timed I/O port pins and status
`timescale 1ns/1ps
module tio_port_monitor #(parameter WIDTH = 4) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Configuration
   input wire cfg_port_en,
   input wire cfg_dir_out,
   input wire cfg_open_coll,
   input wire cfg_strobe_in_en,
   input wire clk_sel_set,
   input wire [2:0] clk_sel,
   input wire link_en,
   input wire [WIDTH-1:0] narrow_taken,
   // Core side and status
   input wire core_wr_ready,
   input wire core_rd_valid,
   input wire [15:0] port_count,
   input wire [15:0] port_stamp,
   input wire [2:0] clk_sel_now,
   // Pins
   input wire [WIDTH-1:0] pin_out,
   input wire [WIDTH-1:0] pin_oe_n,
   input wire strobe_output
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Block zero always ticks every cycle, so slices land back to back
   sequence s_load;
      $rose(strobe_output) && cfg_port_en && !cfg_strobe_in_en &&
         clk_sel_now == 3'h0;
   endsequence
   sequence s_slices;
      strobe_output [*8];
   endsequence
   chk_slice_run: assert property (s_load |-> s_slices)
      else $error("output word cut short");
   chk_load_stamp: assert property (s_load |->
      port_stamp == port_count - 16'h0001) else $error("bad stamp");
   chk_count_step: assert property ($past(reset_n) &&
      $past(cfg_port_en) && $past(clk_sel_now) == 3'h0 &&
      !$past(cfg_strobe_in_en) |-> port_count == $past(port_count) + 16'h0001)
      else $error("counter missed a tick");
   chk_count_idle: assert property ($past(reset_n) &&
      !$past(cfg_port_en) |-> port_count == $past(port_count))
      else $error("counter moved while idle");
   chk_reset_block: assert property ($rose(reset_n) |->
      clk_sel_now == 3'h0 && port_count == 16'h0000)
      else $error("bad state after reset");
   chk_sel_load: assert property (clk_sel_set && clk_sel <= 3'h5 |=>
      clk_sel_now == $past(clk_sel)) else $error("block not selected");
   chk_sel_ignore: assert property (clk_sel_set && clk_sel > 3'h5 |=>
      $stable(clk_sel_now)) else $error("bad block taken");
   chk_in_float: assert property (!cfg_dir_out || !cfg_port_en |->
      pin_oe_n == {WIDTH{1'b1}}) else $error("input port drives");
   chk_link_float: assert property (link_en |->
      pin_oe_n == {WIDTH{1'b1}}) else $error("link pins driven");
   chk_taken_float: assert property (
      (pin_oe_n & narrow_taken) == narrow_taken) else $error("taken pin driven");
   chk_oc_low: assert property (cfg_open_coll |->
      pin_out == {WIDTH{1'b0}}) else $error("open collector drives high");
   chk_wr_refuse: assert property (!cfg_dir_out |-> !core_wr_ready)
      else $error("write taken on input port");
endmodule
bind tio_port tio_port_monitor #(.WIDTH(WIDTH)) mon_u (
   .sys_clk(sys_clk), .reset_n(reset_n), .cfg_port_en(cfg_port_en),
   .cfg_dir_out(cfg_dir_out), .cfg_open_coll(cfg_open_coll),
   .cfg_strobe_in_en(cfg_strobe_in_en), .clk_sel_set(clk_sel_set),
   .clk_sel(clk_sel), .link_en(link_en), .narrow_taken(narrow_taken),
   .core_wr_ready(core_wr_ready), .core_rd_valid(core_rd_valid),
   .port_count(port_count), .port_stamp(port_stamp),
   .clk_sel_now(clk_sel_now), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .strobe_output(strobe_output));

// ---- sim/tio_pins_model.sv ----
// Application hardware on the port pins, strobe and clock pin
`timescale 1ns/1ps
module tio_pins_model #(parameter WIDTH = 4) (
   // Clock
   input wire sys_clk,
   // Port pins
   input wire [WIDTH-1:0] pin_out,
   input wire [WIDTH-1:0] pin_oe_n,
   output wire [WIDTH-1:0] pin_in,
   output wire strobe_input,
   output wire cb_src_pin,
   // Controls
   input wire drive_en,
   input wire stall,
   input wire clk_run
);
   reg [WIDTH-1:0] cnt_reg = 0;
   reg [1:0] phase_reg = 0;
   reg src_reg = 0;
   // Released pins sit at the pull-up unless we drive a changing pattern
   assign pin_in = (~pin_oe_n & pin_out) |
      (pin_oe_n & (drive_en ? cnt_reg : {WIDTH{1'b1}}));
   assign strobe_input = !stall;
   assign cb_src_pin = src_reg;
   always @(posedge sys_clk) begin
      cnt_reg <= cnt_reg + 1'b1;
      phase_reg <= phase_reg + 1'b1;
      src_reg <= clk_run & phase_reg[1];
   end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the timed I/O port
`timescale 1ns/1ps
module tb;
   logic sys_clk = 0, reset_n = 0, cfg_port_en = 0, cfg_dir_out = 0;
   logic cfg_open_coll = 0, cfg_strobe_in_en = 0, clk_sel_set = 0;
   logic link_en = 0, core_wr_valid = 0, core_rd_ready = 0, time_set = 0;
   logic cond_set = 0, overrun_clr = 0, drive_en = 0, stall = 0, clk_run = 0;
   logic [2:0] clk_sel = 0, clk_sel_now;
   logic [4:0] cb_src_ext = 0;
   logic [39:0] cb_div = 0;
   logic [3:0] narrow_taken = 0, cond_value = 0, pin_in, pin_out, pin_oe_n;
   logic [1:0] cond_mode = 0;
   logic [15:0] time_value = 0, port_count, port_stamp;
   logic [31:0] core_wr_data = 0, core_rd_data;
   logic core_wr_ready, core_rd_valid, time_armed, cond_armed, overrun;
   logic strobe_input, strobe_output, cb_src_pin;
   int errors = 0, tests_run = 0, cyc = 0;
   tio_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
      .cfg_port_en(cfg_port_en), .cfg_dir_out(cfg_dir_out),
      .cfg_open_coll(cfg_open_coll), .cfg_strobe_in_en(cfg_strobe_in_en),
      .clk_sel_set(clk_sel_set), .clk_sel(clk_sel), .cb_src_ext(cb_src_ext),
      .cb_div(cb_div), .cb_src_pin(cb_src_pin), .link_en(link_en),
      .narrow_taken(narrow_taken), .core_wr_valid(core_wr_valid),
      .core_wr_data(core_wr_data), .core_wr_ready(core_wr_ready),
      .core_rd_valid(core_rd_valid), .core_rd_data(core_rd_data),
      .core_rd_ready(core_rd_ready), .time_set(time_set),
      .time_value(time_value), .cond_set(cond_set), .cond_mode(cond_mode),
      .cond_value(cond_value), .port_count(port_count),
      .port_stamp(port_stamp), .clk_sel_now(clk_sel_now),
      .time_armed(time_armed), .cond_armed(cond_armed), .overrun(overrun),
      .overrun_clr(overrun_clr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .strobe_input(strobe_input),
      .strobe_output(strobe_output));
   tio_pins_model pm_u (.sys_clk(sys_clk), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_in(pin_in), .strobe_input(strobe_input),
      .cb_src_pin(cb_src_pin), .drive_en(drive_en), .stall(stall),
      .clk_run(clk_run));
   initial forever #12.5 sys_clk = ~sys_clk;
   task report_and_stop;
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // The whole run needs well under two thousand cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         report_and_stop();
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task do_reset(input int n);
      @(posedge sys_clk);
      reset_n <= 0;
      cfg_port_en <= 0;
      cfg_dir_out <= 0;
      cfg_open_coll <= 0;
      cfg_strobe_in_en <= 0;
      link_en <= 0;
      narrow_taken <= 0;
      drive_en <= 0;
      clk_run <= 0;
      repeat (n) @(posedge sys_clk);
      reset_n <= 1;
      @(posedge sys_clk);
      #1;
   endtask
   task t_output;
      logic [31:0] w;
      int k;
      for (int oc = 0; oc < 2; oc++) begin
         w = oc ? 32'h0f0f5a3c : 32'h87654321;
         do_reset(2);
         @(posedge sys_clk);
         cfg_dir_out <= 1;
         cfg_port_en <= 1;
         cfg_open_coll <= oc[0];
         narrow_taken <= 4'h2;
         time_set <= 1;
         time_value <= 16'h0014;
         core_wr_valid <= 1;
         core_wr_data <= w;
         @(posedge sys_clk);
         time_set <= 0;
         core_wr_valid <= 0;
         k = 0;
         while (strobe_output !== 1'b1 && k < 40) begin
            @(posedge sys_clk);
            #1;
            k++;
         end
         chk("stamp", 32'h14, port_stamp);
         chk("oe_n", (oc ? w[3:0] : 4'h0) | 4'h2, pin_oe_n);
         for (int i = 0; i < 8; i++) begin
            chk("pins", w[i*4+:4] | (oc ? 4'h2 : 4'h0), oc ? pin_in : pin_out);
            chk("strobe_output", 1, strobe_output);
            @(posedge sys_clk);
            #1;
         end
         chk("strobe_output", 0, strobe_output);
         chk("time_armed", 0, time_armed);
      end
      @(posedge sys_clk);
      link_en <= 1;
      @(posedge sys_clk);
      #1 chk("link oe_n", 4'hf, pin_oe_n);
   endtask
   task t_input(input logic [1:0] mode, input logic [3:0] v);
      logic [31:0] w;
      logic [3:0] s;
      int k;
      do_reset(2);
      @(posedge sys_clk);
      drive_en <= 1;
      cond_set <= 1;
      cond_mode <= mode;
      cond_value <= v;
      @(posedge sys_clk);
      cond_set <= 0;
      cfg_port_en <= 1;
      k = 0;
      #1 while (core_rd_valid !== 1'b1 && k < 40) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      w = core_rd_data;
      chk("cond hit", mode == 2'h1, w[3:0] == v);
      for (int i = 1; i < 8; i++) begin
         s = w[3:0] + i[3:0];
         chk("slice", s, w[i*4+:4]);
      end
      chk("cond_armed", 0, cond_armed);
      chk("overrun", 1, overrun);
      @(posedge sys_clk);
      core_rd_ready <= 1;
      cfg_port_en <= 0;
      overrun_clr <= 1;
      @(posedge sys_clk);
      core_rd_ready <= 0;
      overrun_clr <= 0;
      #1 chk("rd pop", 0, core_rd_valid);
      chk("overrun clr", 0, overrun);
   endtask
   task t_fill;
      logic r;
      logic [15:0] c;
      int n, k;
      do_reset(2);
      @(posedge sys_clk);
      cfg_dir_out <= 1;
      core_wr_valid <= 1;
      core_wr_data <= 32'h5555aaaa;
      n = 0;
      for (k = 0; k < 20; k++) begin
         #1 r = core_wr_ready;
         @(posedge sys_clk);
         if (r === 1'b1) n++;
      end
      core_wr_valid <= 0;
      cfg_strobe_in_en <= 1;
      stall <= 1;
      cfg_port_en <= 1;
      chk("fifo fill", 16, n);
      repeat (2) @(posedge sys_clk);
      #1 c = port_count;
      repeat (10) @(posedge sys_clk);
      #1 chk("stalled count", c + 16'h000a, port_count);
      chk("stalled strobe", 0, strobe_output);
      chk("stalled load", 0, core_wr_ready);
      @(posedge sys_clk);
      stall <= 0;
      k = 0;
      repeat (4) @(posedge sys_clk);
      #1 chk("strobe_output", 1, strobe_output);
      while (strobe_output !== 1'b0 && k < 200) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      chk("fifo drained", 1, core_wr_ready);
   endtask
   task t_clk;
      logic [15:0] c;
      do_reset(2);
      @(posedge sys_clk);
      cb_div <= 40'h0000000103;
      cb_src_ext <= 5'h02;
      clk_run <= 1;
      cfg_port_en <= 1;
      for (int b = 1; b < 3; b++) begin
         @(posedge sys_clk);
         clk_sel_set <= 1;
         clk_sel <= b[2:0];
         @(posedge sys_clk);
         clk_sel_set <= 0;
         repeat (3) @(posedge sys_clk);
         #1 c = port_count;
         repeat (40) @(posedge sys_clk);
         #1 chk("block rate", b == 1 ? 10 : 5, port_count - c);
      end
      @(posedge sys_clk);
      clk_sel_set <= 1;
      clk_sel <= 3'h6;
      @(posedge sys_clk);
      clk_sel_set <= 0;
      @(posedge sys_clk);
      #1 chk("clk_sel_now", 2, clk_sel_now);
   endtask
   initial begin
      do_reset(20);
      chk("port_count", 0, port_count);
      chk("clk_sel_now", 0, clk_sel_now);
      chk("oe_n", 4'hf, pin_oe_n);
      t_output();
      t_input(2'h1, 4'ha);
      t_input(2'h2, 4'h3);
      t_fill();
      t_clk();
      report_and_stop();
   end
endmodule
